// *** ssg_flag_gen.sv ***
// System status flag generator and program input mapping
`timescale 1ns/1ps
// Operation
// - Twenty-four status bits are offered to the user program.
// - Bit one always reads high, bit two always reads low.
// - Toggle bit: high half a second, low half a second, forever.
// - Clock-fault bit high while real-time clock data is in error.
// - Summer-time bit high while daylight saving is active.
// - Field-network error bit on larger variants only.
// - Field-network power-fail bit when supply failure causes error, on larger variants only.
// - Run-entry bit pulses high on stop-to-run change.
// - Inverted run-entry bit pulses low on stop-to-run change.
// - Decoding bit high throughout radio time-signal decoding.
// - Decode-ok bit pulses once on error-free decode completion.
// - Decode-fail bit set when decoding completes with error.
// - Carrier bit follows modem carrier detect on larger variants only.
// - Network-available and remote-access bits follow cellular state on larger variants only.
// - Output-board power bit follows external board supply on larger variants only.
// - Eight sensor-defect bits, one per sensor; small variant gives first six.
// - Fifteen discrete inputs on larger variants, six on the smaller.
// - Analog inputs share first eight positions; six on smaller variant.
// - Larger variants add four field-network and four expansion inputs.
// - Keys used as program inputs lose their navigation function.
// - In monitor mode the confirm key forces a selected input.
module ssg_flag_gen import ssg_pkg::*; #(
    parameter int HALF_SEC_CYCLES = SSG_HALF_PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Configuration and mode
    input wire logic large_variant_i,
    input wire logic run_mode_i,
    input wire logic scan_tick_i,
    input wire logic monitor_mode_i,
    input wire logic [3:0] force_sel_i,
    input wire logic [SSG_NUM_ANALOG_LARGE-1:0] analog_sel_i,
    input wire logic [SSG_NUM_KEYS-1:0] key_as_input_i,
    // Subsystem status and raw inputs
    input wire ssg_status_t status_i,
    input wire logic [SSG_NUM_DISCRETE_LARGE-1:0] discrete_inputs_i,
    input wire logic [SSG_NUM_FIELDNET-1:0] fieldnet_inputs_i,
    input wire logic [SSG_NUM_EXPANSION-1:0] expansion_inputs_i,
    input wire logic [SSG_NUM_KEYS-1:0] keys_i,
    // To the user program and menu
    output logic [SSG_NUM_BITS-1:0] sys_bits_o,
    output ssg_prog_in_t prog_in_o,
    output logic [SSG_NUM_KEYS-1:0] key_nav_o
);

    // ==========================================================
    // Half-second divider
    logic [31:0] tog_cnt;
    logic toggle;
    wire tog_wrap = (tog_cnt == 32'(HALF_SEC_CYCLES - 1));

    // Counter reloads every half second and flips the toggle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tog_cnt <= '0;
            toggle <= SSG_TOGGLE_RST;
        end else begin
            tog_cnt <= tog_wrap ? '0 : tog_cnt + 32'h00000001;
            if (tog_wrap) begin
                toggle <= ~toggle;
            end
        end
    end

    // ==========================================================
    // Event capture held until the next evaluation cycle
    logic run_q;
    logic busy_q;
    logic pend_run;
    logic pend_ok;
    logic ts_fail;
    logic run_pulse;
    logic ok_pulse;
    wire run_rise = run_mode_i & ~run_q;
    wire busy_rise = status_i.timesig_busy & ~busy_q;
    wire ts_ok_ev = status_i.timesig_done & ~status_i.timesig_err;
    wire ts_err_ev = status_i.timesig_done & status_i.timesig_err;

    // Events may land mid-scan; parking them means no consumer misses one
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
            busy_q <= 1'b0;
            pend_run <= 1'b0;
            pend_ok <= 1'b0;
            run_pulse <= 1'b0;
            ok_pulse <= 1'b0;
        end else begin
            run_q <= run_mode_i;
            busy_q <= status_i.timesig_busy;
            // Set wins over the clear taken at the scan tick
            pend_run <= run_rise | (pend_run & ~scan_tick_i);
            pend_ok <= ts_ok_ev | (pend_ok & ~scan_tick_i);
            if (scan_tick_i) begin
                run_pulse <= pend_run;
                ok_pulse <= pend_ok;
            end
        end
    end

    // Failure stays until a new decode starts or a decode succeeds
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ts_fail <= 1'b0;
        end else begin
            ts_fail <= ts_err_ev | (ts_fail & ~busy_rise & ~ts_ok_ev);
        end
    end

    // ==========================================================
    // Status vector assembly
    logic [SSG_NUM_BITS-1:0] next_bits;
    wire [SSG_NUM_SENSOR-1:0] sensor_mask = large_variant_i ? 8'hFF : 8'h3F;

    assign next_bits[SSG_B_HIGH] = 1'b1;
    assign next_bits[SSG_B_LOW] = 1'b0;
    assign next_bits[SSG_B_TOGGLE] = toggle;
    assign next_bits[SSG_B_CLK_FAULT] = status_i.rtc_data_err;
    assign next_bits[SSG_B_SUMMER] = status_i.dst_active;
    assign next_bits[SSG_B_FN_ERR] = large_variant_i & status_i.fieldnet_err;
    assign next_bits[SSG_B_FN_PWR] = large_variant_i & status_i.fieldnet_pwr_err;
    assign next_bits[SSG_B_RUN_PULSE] = run_pulse;
    assign next_bits[SSG_B_RUN_PULSE_INV] = ~run_pulse;
    assign next_bits[SSG_B_TS_BUSY] = status_i.timesig_busy;
    assign next_bits[SSG_B_TS_OK] = ok_pulse;
    assign next_bits[SSG_B_CARRIER] = large_variant_i & status_i.modem_dcd;
    assign next_bits[SSG_B_CELL_NET] = large_variant_i & status_i.cell_net_up;
    assign next_bits[SSG_B_CELL_REMOTE] = large_variant_i & status_i.cell_remote;
    assign next_bits[SSG_B_TS_FAIL] = ts_fail;
    assign next_bits[SSG_B_BOARD_PWR] = large_variant_i & status_i.out_board_pwr;
    assign next_bits[SSG_B_SENSOR0 +: SSG_NUM_SENSOR] = status_i.sensor_defect & sensor_mask;

    // Registered so every output is a clean flop
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_bits_o <= SSG_BITS_RST;
        end else begin
            sys_bits_o <= next_bits;
        end
    end

    // ==========================================================
    // Keys: split between program use and menu navigation
    logic confirm_q;
    wire [SSG_NUM_KEYS-1:0] next_nav = keys_i & ~key_as_input_i;
    wire confirm_press = next_nav[SSG_KEY_CONFIRM] & ~confirm_q;

    // Confirm edge only counts when the key still navigates
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            confirm_q <= 1'b0;
            key_nav_o <= '0;
        end else begin
            confirm_q <= next_nav[SSG_KEY_CONFIRM];
            key_nav_o <= next_nav;
        end
    end

    // ==========================================================
    // Per-input forcing and variant masking
    wire [SSG_NUM_DISCRETE_LARGE-1:0] force_on;
    wire [SSG_NUM_DISCRETE_LARGE-1:0] next_disc;
    wire [SSG_NUM_ANALOG_LARGE-1:0] next_ana;

    genvar gi;
    generate
        for (gi = 0; gi < SSG_NUM_DISCRETE_LARGE; gi++) begin : g_in
            localparam bit IS_SMALL = (gi < SSG_NUM_DISCRETE_SMALL);
            localparam bit IS_ANA = (gi < SSG_NUM_ANALOG_LARGE);
            localparam bit ANA_SMALL = (gi < SSG_NUM_ANALOG_SMALL);
            logic on_q;
            logic val_q;
            wire avail = large_variant_i | IS_SMALL;
            wire sel = (force_sel_i == 4'(gi));
            wire ana = IS_ANA & analog_sel_i[gi] & (large_variant_i | ANA_SMALL);
            wire level = on_q ? val_q : discrete_inputs_i[gi];

            // Each confirm press flips the forced level; leaving monitor releases it
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    on_q <= 1'b0;
                    val_q <= 1'b0;
                end else if (!monitor_mode_i) begin
                    on_q <= 1'b0;
                end else if (confirm_press && sel && avail) begin
                    on_q <= 1'b1;
                    val_q <= on_q ? ~val_q : ~discrete_inputs_i[gi];
                end
            end

            // Per-entry flops keep one driver per process
            assign force_on[gi] = on_q;

            // Analog use takes the position off the discrete path
            assign next_disc[gi] = avail & ~ana & level;
            if (IS_ANA) begin : g_ana
                assign next_ana[gi] = ana;
            end
        end
    endgenerate

    // Extra sources exist only on the larger variants
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_in_o <= '0;
        end else begin
            prog_in_o.discrete_inputs <= next_disc;
            prog_in_o.analog_inputs <= next_ana;
            prog_in_o.fieldnet_inputs <= large_variant_i ? fieldnet_inputs_i : 4'h0;
            prog_in_o.expansion_inputs <= large_variant_i ? expansion_inputs_i : 4'h0;
            prog_in_o.keys <= keys_i & key_as_input_i;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_const;
        ##1 (sys_bits_o[SSG_B_HIGH] && !sys_bits_o[SSG_B_LOW]);
    endproperty
    a_const: assert property (p_const) else $error("constant bits wrong");

    property p_toggle_flip;
        tog_wrap |=> ##1 (sys_bits_o[SSG_B_TOGGLE] != $past(sys_bits_o[SSG_B_TOGGLE]));
    endproperty
    a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not flip");

    property p_toggle_hold;
        !tog_wrap ##1 1 |=> $stable(sys_bits_o[SSG_B_TOGGLE]);
    endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved early");

    property p_run_inv;
        ##1 (sys_bits_o[SSG_B_RUN_PULSE] != sys_bits_o[SSG_B_RUN_PULSE_INV]);
    endproperty
    a_run_inv: assert property (p_run_inv) else $error("run pulse pair disagree");

    property p_run_pulse;
        pend_run && scan_tick_i |=> ##1 sys_bits_o[SSG_B_RUN_PULSE];
    endproperty
    a_run_pulse: assert property (p_run_pulse) else $error("run pulse missing");

    property p_run_hold;
        run_pulse && !scan_tick_i |=> run_pulse;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("pulse shorter than a scan");

    property p_run_drop;
        scan_tick_i && !pend_run |=> !run_pulse;
    endproperty
    a_run_drop: assert property (p_run_drop) else $error("pulse longer than a scan");

    property p_ts_fail;
        ts_err_ev |=> ##1 sys_bits_o[SSG_B_TS_FAIL];
    endproperty
    a_ts_fail: assert property (p_ts_fail) else $error("decode failure not flagged");

    property p_carrier;
        1 |=> sys_bits_o[SSG_B_CARRIER] == $past(large_variant_i && status_i.modem_dcd);
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier bit wrong");

    property p_small_sensor;
        !large_variant_i |=> sys_bits_o[SSG_B_SENSOR0+7 -: 2] == 2'h0;
    endproperty
    a_small_sensor: assert property (p_small_sensor) else $error("small variant sensor bits set");

    property p_small_disc;
        !large_variant_i |=> prog_in_o.discrete_inputs[14:6] == 9'h000;
    endproperty
    a_small_disc: assert property (p_small_disc) else $error("small variant extra inputs");

    property p_key_nav;
        1 |=> (key_nav_o & $past(key_as_input_i)) == 8'h00;
    endproperty
    a_key_nav: assert property (p_key_nav) else $error("program key still navigates");

    property p_ok_pulse;
        pend_ok && scan_tick_i |=> ##1 sys_bits_o[SSG_B_TS_OK];
    endproperty
    a_ok_pulse: assert property (p_ok_pulse) else $error("decode ok pulse missing");

    property p_ok_drop;
        scan_tick_i && !pend_ok |=> !ok_pulse;
    endproperty
    a_ok_drop: assert property (p_ok_drop) else $error("decode ok pulse too long");

    property p_ts_busy;
        1 |=> sys_bits_o[SSG_B_TS_BUSY] == $past(status_i.timesig_busy);
    endproperty
    a_ts_busy: assert property (p_ts_busy) else $error("decoding bit wrong");

    property p_small_extra;
        !large_variant_i |=> (prog_in_o.fieldnet_inputs | prog_in_o.expansion_inputs) == 4'h0;
    endproperty
    a_small_extra: assert property (p_small_extra) else $error("small variant extra sources");

    property p_force_release;
        !monitor_mode_i |=> force_on == 15'h0000;
    endproperty
    a_force_release: assert property (p_force_release) else $error("force kept outside monitor");

    c_run_pulse: cover property (run_rise ##[1:50] sys_bits_o[SSG_B_RUN_PULSE]);
    c_ts_fail: cover property (ts_err_ev ##2 sys_bits_o[SSG_B_TS_FAIL]);
    c_toggle: cover property (tog_wrap ##2 sys_bits_o[SSG_B_TOGGLE]);
    c_force: cover property (confirm_press && monitor_mode_i ##1 (force_on != '0));

endmodule

// *** ssg_pkg.sv ***
// Shared constants and types of the system status flag generator
package ssg_pkg;

    // ==========================================================
    // Sizes
    localparam int SSG_NUM_BITS = 24;
    localparam int SSG_NUM_DISCRETE_LARGE = 15;
    localparam int SSG_NUM_DISCRETE_SMALL = 6;
    localparam int SSG_NUM_ANALOG_LARGE = 8;
    localparam int SSG_NUM_ANALOG_SMALL = 6;
    localparam int SSG_NUM_FIELDNET = 4;
    localparam int SSG_NUM_EXPANSION = 4;
    localparam int SSG_NUM_KEYS = 8;
    localparam int SSG_NUM_SENSOR = 8;

    // ==========================================================
    // Timing: toggle half period from the 125 MHz clock
    localparam int SSG_CLK_KHZ = 125000;
    localparam int SSG_HALF_PERIOD_MS = 500;
    localparam int SSG_HALF_PERIOD_CYCLES = SSG_HALF_PERIOD_MS * SSG_CLK_KHZ;

    // ==========================================================
    // Bit positions in the status vector
    localparam int SSG_B_HIGH = 0;
    localparam int SSG_B_LOW = 1;
    localparam int SSG_B_TOGGLE = 2;
    localparam int SSG_B_CLK_FAULT = 3;
    localparam int SSG_B_SUMMER = 4;
    localparam int SSG_B_FN_ERR = 5;
    localparam int SSG_B_FN_PWR = 6;
    localparam int SSG_B_RUN_PULSE = 7;
    localparam int SSG_B_RUN_PULSE_INV = 8;
    localparam int SSG_B_TS_BUSY = 9;
    localparam int SSG_B_TS_OK = 10;
    localparam int SSG_B_CARRIER = 11;
    localparam int SSG_B_CELL_NET = 12;
    localparam int SSG_B_CELL_REMOTE = 13;
    localparam int SSG_B_TS_FAIL = 14;
    localparam int SSG_B_BOARD_PWR = 15;
    localparam int SSG_B_SENSOR0 = 16;
    localparam int SSG_KEY_CONFIRM = 0;

    // ==========================================================
    // Reset values
    localparam logic [23:0] SSG_BITS_RST = 24'h000101;
    localparam logic SSG_TOGGLE_RST = 1'b1;

    // Levels and events from the internal subsystems
    typedef struct packed {
        logic rtc_data_err;
        logic dst_active;
        logic fieldnet_err;
        logic fieldnet_pwr_err;
        logic timesig_busy;
        logic timesig_done;
        logic timesig_err;
        logic modem_dcd;
        logic cell_net_up;
        logic cell_remote;
        logic out_board_pwr;
        logic [SSG_NUM_SENSOR-1:0] sensor_defect;
    } ssg_status_t;

    // Signal sources handed to the user program
    typedef struct packed {
        logic [SSG_NUM_DISCRETE_LARGE-1:0] discrete_inputs;
        logic [SSG_NUM_ANALOG_LARGE-1:0] analog_inputs;
        logic [SSG_NUM_FIELDNET-1:0] fieldnet_inputs;
        logic [SSG_NUM_EXPANSION-1:0] expansion_inputs;
        logic [SSG_NUM_KEYS-1:0] keys;
    } ssg_prog_in_t;

endpackage

// *** ssg_src_model.sv ***
// Model of the program evaluation sequencer that feeds the flag generator
`timescale 1ns/1ps
module ssg_src_model #(
    parameter int SCAN = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Start of each evaluation cycle
    output logic scan_tick_o
);
    int cnt;

    // ==========================================================
    // Scan tick every SCAN clocks; pulses must last one scan, so spacing is fixed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            scan_tick_o <= 1'b0;
        end else begin
            cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
            scan_tick_o <= (cnt == SCAN - 1);
        end
    end
endmodule

// *** ssg_flag_gen_tb.sv ***
// Self-checking testbench of the system status flag generator
`timescale 1ns/1ps
module ssg_flag_gen_tb import ssg_pkg::*; ;
    localparam int HALF = 8;
    localparam int SCAN = 6;
    localparam logic [23:0] LVL = 24'hFFBA78; // All level-type bits
    localparam logic [23:0] SMALL_OFF = 24'hC0B860; // Bits absent on the small variant
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic large_i = 1'b1;
    logic run_i = 1'b0;
    logic mon_i = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] asel = 8'h00;
    logic [7:0] kin = 8'h00;
    logic [7:0] keys = 8'h00;
    logic [14:0] disc = 15'h0000;
    logic [3:0] fn = 4'h0;
    logic [3:0] ex = 4'h0;
    ssg_status_t st = '0;
    wire logic scan;
    logic [23:0] bits;
    ssg_prog_in_t pin;
    logic [7:0] nav;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int src[9] = '{18, 17, 16, 15, 14, 11, 10, 9, 8};
    int dst[9] = '{3, 4, 5, 6, 9, 11, 12, 13, 15};

    ssg_src_model #(.SCAN(SCAN)) ssg_src_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scan_tick_o(scan));
    ssg_flag_gen #(.HALF_SEC_CYCLES(HALF)) ssg_flag_gen_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .large_variant_i(large_i), .run_mode_i(run_i),
        .scan_tick_i(scan), .monitor_mode_i(mon_i), .force_sel_i(sel), .analog_sel_i(asel),
        .key_as_input_i(kin), .status_i(st), .discrete_inputs_i(disc), .fieldnet_inputs_i(fn),
        .expansion_inputs_i(ex), .keys_i(keys), .sys_bits_o(bits), .prog_in_o(pin), .key_nav_o(nav));

    // ==========================================================
    // Clock and hang guard
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Helpers; inputs move and outputs are sampled at the falling edge
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("Mismatches %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bounded wait for a pulse, then its length in clocks
    task automatic measure(input int b);
        int n;
        n = 0;
        while (bits[b] !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        n = 0;
        while (bits[b] === 1'b1 && n < 40) begin
            if (b == 7) chk("run_entry_pulse_inv", 0, bits[8]);
            n++;
            step(1);
        end
        chk("pulse_len", SCAN, n);
    endtask
    // Bounded wait for the toggle to flip; the wait itself is checked as the phase length
    task automatic phase();
        logic b;
        int n;
        b = bits[2];
        n = 0;
        while (bits[2] === b && n < 30) begin
            step(1);
            n++;
        end
        chk("toggle_phase", HALF, n);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int i;
        int v;
        int d;
        step(20);
        sys_rst_i = 1'b0;
        step(1);
        chk("const_high", 1, bits[0]);
        chk("const_low", 0, bits[1]);
        phase();
        phase();
        phase();
        // One level source at a time, both variants
        for (v = 1; v >= 0; v--) begin
            large_i = v[0];
            for (i = 0; i < 17; i++) begin
                st = '0;
                st[(i < 9) ? src[i] : i - 9] = 1'b1;
                d = (i < 9) ? dst[i] : i + 7;
                step(1);
                chk("level_bits", (24'h1 << d) & (v ? 24'hFFFFFF : ~SMALL_OFF), bits & LVL);
            end
        end
        st = '0;
        large_i = 1'b1;
        run_i = 1'b1;
        measure(7);
        chk("run_entry_pulse_inv_idle", 1, bits[8]);
        // Decode with error, then a good decode that clears it
        st.timesig_done = 1'b1;
        st.timesig_err = 1'b1;
        step(1);
        st = '0;
        step(3);
        chk("timesig_fail", 1, bits[14]);
        st.timesig_done = 1'b1;
        step(1);
        st = '0;
        measure(10);
        chk("timesig_fail_clear", 0, bits[14]);
        // Input mapping per variant; analog positions leave the discrete view
        disc = 15'h7FFF;
        asel = 8'hC3;
        fn = 4'hF;
        ex = 4'hF;
        step(1);
        chk("discrete_large", 15'h7F3C, pin.discrete_inputs);
        chk("analog_large", 8'hC3, pin.analog_inputs);
        chk("fieldnet_large", 4'hF, pin.fieldnet_inputs);
        chk("expansion_large", 4'hF, pin.expansion_inputs);
        large_i = 1'b0;
        step(1);
        chk("discrete_small", 15'h003C, pin.discrete_inputs);
        chk("analog_small", 8'h03, pin.analog_inputs);
        chk("fieldnet_small", 4'h0, pin.fieldnet_inputs | pin.expansion_inputs);
        kin = 8'hF0;
        keys = 8'hFF;
        step(1);
        chk("key_nav", 8'h0F, nav);
        chk("prog_keys", 8'hF0, pin.keys);
        // Confirm key forces a selected input in monitor mode only
        keys = 8'h00;
        kin = 8'h00;
        large_i = 1'b1;
        asel = 8'h00;
        disc = 15'h0000;
        mon_i = 1'b1;
        sel = 4'h2;
        step(1);
        keys = 8'h01;
        step(3);
        chk("forced_input", 15'h0004, pin.discrete_inputs);
        // Second press forces low against a high raw level
        keys = 8'h00;
        disc = 15'h0004;
        step(1);
        keys = 8'h01;
        step(3);
        chk("forced_off", 15'h0000, pin.discrete_inputs);
        keys = 8'h00;
        step(1);
        mon_i = 1'b0;
        step(3);
        chk("force_released", 15'h0004, pin.discrete_inputs);
        tally_and_finish();
    end
endmodule
